// File: logic/tcs_sequencer.sv
// timing generator for a three channel linear image sensor
// Overview of operation
// - raise overflow at transfer, drop later in line
// - independent overflow gate per colour channel
// - raise overflow gate during inner gate fall
// - overflow fall aligned with phase clock edges
// - slow overflow falls for high dynamic range are left to the analog driver
// - summing clock half rate, 75 percent duty
// - full resolution: summing clock follows phase two
// - transfer gates off throughout integration
// - halt phase one high, phase two low first
// - then both transfer gates on
// - inner gate off first, then outer gate
// - resume complementary clocking after outer off
// - reset clock pulse before every output pixel
// - keep phase clocks symmetric
`timescale 1ns/1ps
`default_nettype none
module tcs_sequencer (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst,
   // control
   input  wire logic              run,
   input  wire tcs_pkg::tcs_cfg_t cfg,
   // sensor pins
   output tcs_pkg::tcs_pins_t     pins_q,
   // sampling strobe for the video converters
   output logic                   pixel_valid_q,
   output logic                   line_start_q
);
   import tcs_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_HALT,
      ST_TG_ON,
      ST_TG1_OFF,
      ST_TG2_OFF,
      ST_READ
   } tcs_state_t;

   tcs_state_t        state_q;
   tcs_cfg_t          cfg_q;
   logic [TIM_W-1:0]  tim_q;
   logic [PIX_W-1:0]  pix_q;
   logic              half_q;
   logic              per_q;
   logic              tim_done;
   logic              phase_edge;
   logic              line_go;
   logic [CH_NUM-1:0] gate_w;
   logic [PIX_W-1:0]  expo_w [CH_NUM];
   logic              og_edge;
   logic              ph1_q;
   logic              ph2_q;
   logic              sum_q;
   logic              rclk_q;
   logic              itg_q;
   logic              otg_q;

   function automatic logic [TIM_W-1:0] cyc(input int unsigned n);
      cyc = TIM_W'(n - 1);
   endfunction

   assign tim_done   = (tim_q == '0);
   assign phase_edge = (state_q == ST_READ) && tim_done;
   // first cycle of the inner gate fall, so overflow rises with it
   assign line_go    = (state_q == ST_TG1_OFF) && (tim_q == cyc(TG_STEP_CYC));
   // cycle in which phase one falls; overflow falls share its artifact
   assign og_edge    = (state_q == ST_READ) && !half_q && (tim_q == cyc(PHASE_HALF_CYC));
   assign expo_w[CH_RED]   = cfg_q.red_expo;
   assign expo_w[CH_GREEN] = cfg_q.green_expo;
   assign expo_w[CH_BLUE]  = cfg_q.blue_expo;

   // settings latched at each line so a line never mixes two settings
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg_q <= '0;
      end else if (state_q == ST_IDLE || state_q == ST_HALT) begin
         cfg_q <= cfg;
      end
   end

   // line sequence
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         tim_q   <= '0;
         pix_q   <= '0;
         half_q  <= 1'b0;
         per_q   <= 1'b0;
      end else begin
         tim_q <= tim_done ? '0 : tim_q - 1'b1;
         case (state_q)
            ST_IDLE: begin
               if (run) begin
                  state_q <= ST_HALT;
                  tim_q   <= cyc(TG_STEP_CYC);
               end
            end
            ST_HALT: begin
               if (tim_done) begin
                  state_q <= ST_TG_ON;
                  tim_q   <= cyc(TG_STEP_CYC);
               end
            end
            ST_TG_ON: begin
               if (tim_done) begin
                  state_q <= ST_TG1_OFF;
                  tim_q   <= cyc(TG_STEP_CYC);
               end
            end
            ST_TG1_OFF: begin
               if (tim_done) begin
                  state_q <= ST_TG2_OFF;
                  tim_q   <= cyc(TG_STEP_CYC);
               end
            end
            ST_TG2_OFF: begin
               if (tim_done) begin
                  state_q <= ST_READ;
                  tim_q   <= cyc(PHASE_HALF_CYC);
                  pix_q   <= PIX_W'(PIXELS_FULL);
                  half_q  <= 1'b0;
                  per_q   <= 1'b0;
               end
            end
            ST_READ: begin
               if (tim_done) begin
                  tim_q  <= cyc(PHASE_HALF_CYC);
                  half_q <= ~half_q;
                  if (half_q) begin
                     per_q <= ~per_q;
                     pix_q <= pix_q - 1'b1;
                     if (pix_q == PIX_W'(1)) begin
                        state_q <= run ? ST_HALT : ST_IDLE;
                        tim_q   <= cyc(TG_STEP_CYC);
                     end
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // register phases and summing gate
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ph1_q <= 1'b1;
         ph2_q <= 1'b0;
         sum_q <= 1'b0;
      end else if (state_q == ST_READ) begin
         ph1_q <= half_q;
         ph2_q <= ~half_q;
         if (cfg_q.mode == TCS_MODE_SUM2) begin
            // low only in the last quarter of two phase two periods
            sum_q <= ~(per_q && half_q);
         end else begin
            sum_q <= ~half_q;
         end
      end else begin
         ph1_q <= 1'b1;
         ph2_q <= 1'b0;
         sum_q <= 1'b0;
      end
   end

   // transfer gates: off except the transfer window
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         itg_q <= 1'b0;
         otg_q <= 1'b0;
      end else begin
         itg_q <= (state_q == ST_TG_ON);
         otg_q <= (state_q == ST_TG_ON) ||
                  (state_q == ST_TG1_OFF);
      end
   end

   // reset clock: pulse at the start of each output pixel period
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rclk_q        <= 1'b0;
         pixel_valid_q <= 1'b0;
      end else begin
         rclk_q        <= (state_q == ST_READ) && !half_q &&
                          (tim_q >= TIM_W'(PHASE_HALF_CYC - RST_PULSE_CYC)) &&
                          (cfg_q.mode == TCS_MODE_FULL || !per_q);
         pixel_valid_q <= phase_edge && half_q &&
                          (cfg_q.mode == TCS_MODE_FULL || per_q);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         line_start_q <= 1'b0;
      end else begin
         line_start_q <= line_go;
      end
   end

   // one independent gate per channel; slow falls are analog driver work
   for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
      tcs_overflow_gate u_og (
         .core_clk   (core_clk),
         .rst        (rst),
         .line_start (line_go),
         .phase_edge (og_edge),
         .pix_left   (pix_q),
         .expo_len   (expo_w[c]),
         .gate_q     (gate_w[c])
      );
   end
   // one flop per pin; the struct only bundles them at the port
   assign pins_q = '{
      phase1_clock:        ph1_q,
      phase2_clock:        ph2_q,
      summing_gate_clock:  sum_q,
      reset_clock:         rclk_q,
      inner_transfer_gate: itg_q,
      outer_transfer_gate: otg_q,
      overflow_gate:       gate_w
   };
endmodule
`default_nettype wire

// File: logic/tcs_pkg.sv
// package for the trilinear sensor clock sequencer
package tcs_pkg;
   // pixels per channel
   localparam int unsigned PIXELS_FULL   = 2098;
   localparam int unsigned PIXELS_SUMMED = 1049;
   // core clock
   localparam int unsigned CLK_PERIOD_NS = 8;
   // half period of one register clock phase, in ns
   localparam int unsigned PHASE_HALF_NS = 64;
   localparam int unsigned PHASE_HALF_CYC =
      (PHASE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // reset clock pulse width, in ns
   localparam int unsigned RST_PULSE_NS  = 16;
   localparam int unsigned RST_PULSE_CYC =
      (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // transfer gate step time, in ns
   localparam int unsigned TG_STEP_NS    = 1000;
   localparam int unsigned TG_STEP_CYC   =
      (TG_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // counter widths and channel count
   localparam int unsigned PIX_W  = 12;
   localparam int unsigned TIM_W  = 8;
   localparam int unsigned CH_NUM = 3;
   // channel indices
   localparam int unsigned CH_RED   = 0;
   localparam int unsigned CH_GREEN = 1;
   localparam int unsigned CH_BLUE  = 2;
   // exposure value that keeps a channel's overflow gate low for the line
   localparam logic [PIX_W-1:0] EXPO_RST = 12'h000;

   typedef enum logic {
      TCS_MODE_FULL,
      TCS_MODE_SUM2
   } tcs_mode_t;

   // sensor pins driven by the sequencer
   typedef struct packed {
      logic               phase1_clock;
      logic               phase2_clock;
      logic               summing_gate_clock;
      logic               reset_clock;
      logic               inner_transfer_gate;
      logic               outer_transfer_gate;
      logic [CH_NUM-1:0]  overflow_gate;
   } tcs_pins_t;

   // per line settings
   typedef struct packed {
      tcs_mode_t          mode;
      logic [PIX_W-1:0]   red_expo;
      logic [PIX_W-1:0]   green_expo;
      logic [PIX_W-1:0]   blue_expo;
   } tcs_cfg_t;
endpackage

// File: logic/tcs_overflow_gate.sv
// one channel's overflow gate exposure control
`timescale 1ns/1ps
`default_nettype none
module tcs_overflow_gate (
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   // line timing
   input  wire logic                      line_start,
   input  wire logic                      phase_edge,
   input  wire logic [tcs_pkg::PIX_W-1:0] pix_left,
   input  wire logic [tcs_pkg::PIX_W-1:0] expo_len,
   // gate out
   output logic                           gate_q
);
   import tcs_pkg::*;
   // raised at transfer so rising artifacts fall in the transfer gap
   // fall only on a phase edge; pixel count to line end equals exposure
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         gate_q <= 1'b0;
      end else if (line_start) begin
         gate_q <= (expo_len != EXPO_RST);
      end else if (gate_q && phase_edge && pix_left <= expo_len) begin
         gate_q <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: sim/tcs_sequencer_asserts.sv
// checker for the sensor clock sequencer
`timescale 1ns/1ps
`default_nettype none
module tcs_sequencer_asserts (
   // clock and reset
   input wire logic               core_clk,
   input wire logic               rst,
   // watched ports
   input wire tcs_pkg::tcs_cfg_t  cfg,
   input wire tcs_pkg::tcs_pins_t pins_q,
   input wire logic               pixel_valid_q,
   input wire logic               line_start_q
);
   import tcs_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   halt_then_tg_a: assert property ($rose(pins_q.inner_transfer_gate) |->
      pins_q.phase1_clock && !pins_q.phase2_clock && pins_q.outer_transfer_gate)
      else $error("gates opened without halt");
   inner_first_a: assert property ($fell(pins_q.outer_transfer_gate) |->
      !pins_q.inner_transfer_gate) else $error("outer gate closed first");
   clock_gates_a: assert property ($changed(pins_q.phase1_clock) |->
      !pins_q.inner_transfer_gate && !pins_q.outer_transfer_gate) else $error("clocked in transfer");
   phase_comp_a: assert property (pins_q.phase1_clock != pins_q.phase2_clock)
      else $error("phases not complementary");
   full_sum_a: assert property (cfg.mode == TCS_MODE_FULL |->
      pins_q.summing_gate_clock == pins_q.phase2_clock) else $error("summing not tied");
   sum_low_a: assert property (cfg.mode == TCS_MODE_SUM2 &&
      $fell(pins_q.summing_gate_clock) |-> !pins_q.summing_gate_clock[*8])
      else $error("summing low too short");
   reset_pulse_a: assert property ($rose(pins_q.reset_clock) |->
      pins_q.reset_clock[*2] ##1 !pins_q.reset_clock) else $error("reset pulse width");
   line_mark_a: assert property ($fell(pins_q.inner_transfer_gate) |-> ##[0:1] line_start_q)
      else $error("line start missing");
   ovf_rise_a: assert property ($rose(pins_q.overflow_gate[CH_RED]) |->
      pins_q.outer_transfer_gate && !pins_q.inner_transfer_gate) else $error("overflow rise");
   ovf_fall_a: assert property ($fell(pins_q.overflow_gate[CH_GREEN]) |->
      $changed(pins_q.phase1_clock) || $past(pins_q.phase1_clock) != $past(pins_q.phase1_clock, 2))
      else $error("overflow fall off phase edge");
   pix_pulse_a: assert property (pixel_valid_q |=> !pixel_valid_q) else $error("pixel strobe long");
endmodule
bind tcs_sequencer tcs_sequencer_asserts chk (.core_clk(core_clk), .rst(rst), .cfg(cfg),
   .pins_q(pins_q), .pixel_valid_q(pixel_valid_q), .line_start_q(line_start_q));
`default_nettype wire

// File: sim/tcs_sensor_model.sv
// behavioural model of the three channel sensor
`timescale 1ns/1ps
`default_nettype none
module tcs_sensor_model (
   // pins from the sequencer
   input wire tcs_pkg::tcs_pins_t        pins,
   input wire logic                      rst,
   // observed charge events
   output logic [15:0]                   dump_cnt,
   output logic [15:0]                   reset_cnt,
   output logic [15:0]                   shift_cnt,
   output logic [tcs_pkg::CH_NUM-1:0]    drain
);
   import tcs_pkg::*;
   // photocurrent lost only while the inner gate is shut
   assign drain = pins.overflow_gate & {CH_NUM{~pins.inner_transfer_gate}};
   // one counter stands for all three registers: they move together
   always @(posedge pins.phase1_clock or posedge rst) begin
      shift_cnt <= rst ? 16'h0000 : shift_cnt + 16'h0001;
   end
   always @(negedge pins.summing_gate_clock or posedge rst) begin
      dump_cnt <= rst ? 16'h0000 : dump_cnt + 16'h0001;
   end
   always @(posedge pins.reset_clock or posedge rst) begin
      reset_cnt <= rst ? 16'h0000 : reset_cnt + 16'h0001;
   end
endmodule
`default_nettype wire

// File: sim/test_trilinear_ccd_clock_sequencer.sv
// testbench for the sensor clock sequencer
`timescale 1ns/1ps
`default_nettype none
module test_trilinear_ccd_clock_sequencer;
   import tcs_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst = 1'b0;
   logic        run = 1'b0;
   tcs_cfg_t    cfg = '0;
   tcs_pins_t   pins_q;
   logic        pixel_valid_q;
   logic        line_start_q;
   logic [15:0] dumps, resets, shifts;
   logic [2:0]  drain, ovf_p = 3'h0;
   int          error_cnt = 0, n_compared = 0, pix_cnt = 0, lines = 0;
   int          fall_at [CH_NUM];
   always #4 core_clk = ~core_clk;
   tcs_sequencer uut (.core_clk(core_clk), .rst(rst), .run(run), .cfg(cfg), .pins_q(pins_q),
      .pixel_valid_q(pixel_valid_q), .line_start_q(line_start_q));
   tcs_sensor_model dev (.pins(pins_q), .rst(rst), .dump_cnt(dumps), .reset_cnt(resets),
      .shift_cnt(shifts), .drain(drain));
   always @(posedge core_clk) begin
      ovf_p <= pins_q.overflow_gate;
      lines <= lines + int'(line_start_q === 1'b1);
      pix_cnt <= (line_start_q === 1'b1) ? 0 : pix_cnt + int'(pixel_valid_q === 1'b1);
      for (int c = 0; c < CH_NUM; c++) begin
         if (ovf_p[c] === 1'b1 && pins_q.overflow_gate[c] === 1'b0) fall_at[c] <= pix_cnt;
      end
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // one line, run dropped mid-line: the line must still complete, then idle
   task automatic scan_line(input tcs_mode_t md, input logic [PIX_W-1:0] er, eg, eb,
                            input int n);
      logic [15:0] d0, r0, s0;
      int          k, l0, left;
      logic [PIX_W-1:0] ex [CH_NUM];
      ex = '{er, eg, eb};
      @(negedge core_clk);
      cfg = '{mode: md, red_expo: er, green_expo: eg, blue_expo: eb};
      run = 1'b1;
      k = 0;
      while (line_start_q !== 1'b1 && k < 2000) begin
         @(posedge core_clk);
         k++;
      end
      @(negedge core_clk);
      run = 1'b0;
      // inner gate just fell: every gated channel now drains
      cmp(16'(drain), 16'({eb != 12'h000, eg != 12'h000, er != 12'h000}));
      s0 = shifts;
      d0 = dumps;
      r0 = resets;
      l0 = lines;
      while (pix_cnt < n && k < 40000) begin
         @(posedge core_clk);
         k++;
      end
      repeat (600) @(posedge core_clk);
      cmp(16'(pix_cnt), 16'(n));
      cmp(dumps - d0, 16'(n));
      cmp(resets - r0, 16'(n));
      cmp(shifts - s0, 16'(PIXELS_FULL));
      cmp(16'(lines - l0), 16'h0000);
      for (int c = 0; c < CH_NUM && md == TCS_MODE_FULL; c++) begin
         left = n - fall_at[c];
         cmp(16'(left >= int'(ex[c]) - 1 && left <= int'(ex[c]) + 1), 16'h0001);
      end
      $display("line done mode %0d pixels %0d", md, pix_cnt);
   endtask
   initial begin
      repeat (90000) @(posedge core_clk);
      error_cnt++;
      close_out();
   end
   initial begin
      // raised by nba so every model process already waits on its edge
      rst <= 1'b1;
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      scan_line(TCS_MODE_FULL, 12'h064, 12'h1F4, 12'h7D0, PIXELS_FULL);
      scan_line(TCS_MODE_SUM2, 12'h000, 12'h000, 12'h000, PIXELS_SUMMED);
      close_out();
   end
endmodule
`default_nettype wire
